// ### core/fcd_pkg.sv
`default_nettype none
package fcd_pkg;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_WORD_PROG = 8'h40;
    localparam logic [7:0] CMD_WORD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_BUF_PROG = 8'he8;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_FACTORY_SETUP = 8'h80;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
    localparam int BUF_WORDS = 32;
    localparam int ST_READY = 7;
    localparam int ST_ERASE_SUSP = 6;
    localparam int ST_ERASE_ERR = 5;
    localparam int ST_PROG_ERR = 4;
    localparam int ST_PROG_SUSP = 2;
    localparam logic [7:0] STATUS_RESET = 8'h80;

    typedef enum {
        RM_ARRAY,
        RM_STATUS,
        RM_QUERY
    } fcd_read_e;

    typedef enum {
        OP_WORD,
        OP_BUFFER,
        OP_FACTORY,
        OP_ERASE,
        OP_LOCK,
        OP_UNLOCK,
        OP_LOCK_DOWN
    } fcd_op_e;

    // one command bus write captured at the strobe edge
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
    } fcd_cycle_s;

    // request to the internal state machine
    typedef struct packed {
        logic [2:0] op;
        logic [23:0] addr;
        logic [15:0] data;
        logic [5:0] count;
    } fcd_req_s;
endpackage : fcd_pkg
`default_nettype wire

// ### core/fcd_decoder.sv
// How it works
// - query code makes later reads show query data on the low eight lines.
// - engine only sets error bits; clear-status code alone clears them.
// - after word-program setup the next write gives address and data to program.
// - while programming only read-status and suspend are acted on.
// - status view refreshes only on chip-enable, output-enable or address-valid toggle.
// - alternate word-program setup code behaves exactly like the primary one.
// - buffered program takes a host-chosen word count, at most thirty-two.
// - confirm after buffer data makes the engine write the buffer.
// - factory setup waits for confirm; once factory mode runs, all else ignored.
// - confirm right after factory setup latches address, data and starts factory mode.
// - erase setup arms an erase of the block given by the confirm cycle.
// - non-confirm after erase setup sets status bits four, five and status mode.
// - confirm after erase setup latches address and data; engine erases block.
// - while erasing only read-status and suspend are acted on.
// - suspend code at any address suspends running program or erase.
// - suspend shows ready plus program-suspended or erase-suspended bit.
// - suspension holds regardless of controls until resume or reset.
// - resume code at any address restarts the suspended operation.
// - after lock setup a code other than lock, unlock, lock-down is sequence error.
// - read-array code selects array reads on all sixteen lines.
// - read-status code or any program or erase command selects status mode.
// - lock second cycle locks, unlocks or locks down the addressed block.
// - command address and data captured on first rising edge of strobe or enable.
`timescale 1ns/100ps
`default_nettype none
module fcd_decoder
    import fcd_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // flash bus pins
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic addr_valid_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [15:0] dq_in,
    // internal state machine side
    input wire logic engine_busy_in,
    input wire logic engine_suspended_in,
    input wire logic engine_prog_err_in,
    input wire logic engine_erase_err_in,
    output logic engine_start_out,
    output fcd_req_s engine_req_out,
    output logic engine_suspend_out,
    output logic engine_resume_out,
    output logic engine_abort_out,
    output logic buf_write_out,
    output logic [4:0] buf_index_out,
    output logic [15:0] buf_data_out,
    // read path
    output logic [1:0] read_mode_out,
    output logic [7:0] status_view_out
);
    typedef enum {
        S_IDLE,
        S_WORD_DATA,
        S_BUF_COUNT,
        S_BUF_DATA,
        S_BUF_CONFIRM,
        S_FACT_CONFIRM,
        S_ERASE_CONFIRM,
        S_LOCK_CODE,
        S_BUSY,
        S_FACTORY
    } fcd_state_e;

    // pin synchronisers: three stages, change counted when stages 2 and 3 agree
    logic [2:0] ce_sync_r, we_sync_r, oe_sync_r, av_sync_r;
    logic ce_q_r, we_q_r, oe_q_r, av_q_r;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ce_sync_r <= 3'h7;
            we_sync_r <= 3'h7;
            oe_sync_r <= 3'h7;
            av_sync_r <= 3'h7;
            ce_q_r <= 1'b1;
            we_q_r <= 1'b1;
            oe_q_r <= 1'b1;
            av_q_r <= 1'b1;
        end else begin
            ce_sync_r <= {ce_sync_r[1:0], ce_n_in};
            we_sync_r <= {we_sync_r[1:0], we_n_in};
            oe_sync_r <= {oe_sync_r[1:0], oe_n_in};
            av_sync_r <= {av_sync_r[1:0], addr_valid_n_in};
            if (ce_sync_r[2] == ce_sync_r[1]) ce_q_r <= ce_sync_r[2];
            if (we_sync_r[2] == we_sync_r[1]) we_q_r <= we_sync_r[2];
            if (oe_sync_r[2] == oe_sync_r[1]) oe_q_r <= oe_sync_r[2];
            if (av_sync_r[2] == av_sync_r[1]) av_q_r <= av_sync_r[2];
        end
    end

    // write cycle open while both strobes low; ends on the first to rise
    logic wr_open_r;
    fcd_cycle_s cyc_r;
    wire wr_active = !ce_q_r && !we_q_r && oe_q_r;
    wire wr_end = wr_open_r && !wr_active;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_open_r <= 1'b0;
            cyc_r <= '0;
        end else begin
            wr_open_r <= wr_active;
            if (wr_active) cyc_r <= '{addr: 24'(addr_in), data: dq_in};
        end
    end

    wire [7:0] code = cyc_r.data[7:0];
    wire is_confirm = code == CMD_CONFIRM;
    wire is_word = code == CMD_WORD_PROG || code == CMD_WORD_PROG_ALT;
    wire is_lock_code = code == CMD_LOCK || is_confirm || code == CMD_LOCK_DOWN;

    fcd_state_e state_r, state_nxt;
    fcd_read_e rmode_r, rmode_nxt;
    logic susp_prog_r, susp_erase_r;
    logic [5:0] count_r;
    logic [4:0] idx_r;
    fcd_req_s req_r;
    logic start_r, susp_r, resume_r;
    logic op_erase_r;

    // next state from the previous command and the new code
    always_comb begin
        state_nxt = state_r;
        rmode_nxt = rmode_r;
        if (wr_end) begin
            case (state_r)
                S_IDLE: begin
                    if (code == CMD_READ_ARRAY) rmode_nxt = RM_ARRAY;
                    else if (code == CMD_READ_STATUS) rmode_nxt = RM_STATUS;
                    else if (code == CMD_READ_QUERY) rmode_nxt = RM_QUERY;
                    if (is_word) state_nxt = S_WORD_DATA;
                    else if (code == CMD_BUF_PROG) state_nxt = S_BUF_COUNT;
                    else if (code == CMD_FACTORY_SETUP) state_nxt = S_FACT_CONFIRM;
                    else if (code == CMD_ERASE_SETUP) state_nxt = S_ERASE_CONFIRM;
                    else if (code == CMD_LOCK_SETUP) state_nxt = S_LOCK_CODE;
                    else if (is_confirm && (susp_prog_r || susp_erase_r))
                        state_nxt = S_BUSY;
                    if (is_word || code == CMD_BUF_PROG || code == CMD_FACTORY_SETUP
                        || code == CMD_ERASE_SETUP) rmode_nxt = RM_STATUS;
                end
                S_WORD_DATA: state_nxt = S_BUSY;
                S_BUF_COUNT: state_nxt = S_BUF_DATA;
                S_BUF_DATA: if (idx_r == 5'(count_r - 6'h01)) state_nxt = S_BUF_CONFIRM;
                S_BUF_CONFIRM: state_nxt = is_confirm ? S_BUSY : S_IDLE;
                S_FACT_CONFIRM: state_nxt = is_confirm ? S_FACTORY : S_IDLE;
                S_ERASE_CONFIRM: begin
                    state_nxt = is_confirm ? S_BUSY : S_IDLE;
                    rmode_nxt = RM_STATUS;
                end
                S_LOCK_CODE: state_nxt = S_IDLE;
                S_BUSY: begin
                    // only read-status and suspend are acted on
                    if (code == CMD_READ_STATUS) rmode_nxt = RM_STATUS;
                    else if (code == CMD_SUSPEND) state_nxt = S_IDLE;
                end
                S_FACTORY: state_nxt = S_FACTORY;
                default: state_nxt = S_IDLE;
            endcase
        end else if (state_r == S_BUSY && !engine_busy_in && !start_r && !resume_r) begin
            state_nxt = S_IDLE;
        end else if (state_r == S_FACTORY && !engine_busy_in && !start_r) begin
            state_nxt = S_IDLE;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= S_IDLE;
            rmode_r <= RM_ARRAY;
        end else begin
            state_r <= state_nxt;
            rmode_r <= rmode_nxt;
        end
    end

    // requests to the internal state machine
    wire go_word = wr_end && state_r == S_WORD_DATA;
    wire go_buf = wr_end && state_r == S_BUF_CONFIRM && is_confirm;
    wire go_fact = wr_end && state_r == S_FACT_CONFIRM && is_confirm;
    wire go_erase = wr_end && state_r == S_ERASE_CONFIRM && is_confirm;
    wire go_lock = wr_end && state_r == S_LOCK_CODE && is_lock_code;
    wire go_susp = wr_end && state_r == S_BUSY && code == CMD_SUSPEND;
    wire go_resume = wr_end && state_r == S_IDLE && is_confirm && (susp_prog_r || susp_erase_r);
    wire bad_seq = wr_end && ((state_r == S_ERASE_CONFIRM && !is_confirm)
        || (state_r == S_LOCK_CODE && !is_lock_code));
    wire clr_status = wr_end && state_r == S_IDLE && code == CMD_CLEAR_STATUS;
    wire [2:0] lock_op = code == CMD_LOCK ? 3'(OP_LOCK)
        : (is_confirm ? 3'(OP_UNLOCK) : 3'(OP_LOCK_DOWN));
    wire [2:0] req_op = go_word ? 3'(OP_WORD) : go_buf ? 3'(OP_BUFFER)
        : go_fact ? 3'(OP_FACTORY) : go_erase ? 3'(OP_ERASE) : lock_op;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            req_r <= '0;
            start_r <= 1'b0;
            susp_r <= 1'b0;
            resume_r <= 1'b0;
            count_r <= '0;
            idx_r <= '0;
            op_erase_r <= 1'b0;
        end else begin
            start_r <= go_word || go_buf || go_fact || go_erase || go_lock;
            susp_r <= go_susp;
            resume_r <= go_resume;
            if (go_word || go_buf || go_fact || go_erase || go_lock)
                req_r <= '{op: req_op, addr: cyc_r.addr, data: cyc_r.data,
                    count: count_r};
            if (go_erase) op_erase_r <= 1'b1;
            else if (go_word || go_buf || go_fact) op_erase_r <= 1'b0;
            if (wr_end && state_r == S_BUF_COUNT) begin
                // host writes N-1; capped at the buffer size
                count_r <= (cyc_r.data >= 16'(BUF_WORDS)) ? 6'(BUF_WORDS)
                    : 6'(cyc_r.data + 16'h0001);
                idx_r <= '0;
            end else if (wr_end && state_r == S_BUF_DATA) begin
                idx_r <= idx_r + 5'h01;
            end
        end
    end

    // suspend flags: held until resume or reset only
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            susp_prog_r <= 1'b0;
            susp_erase_r <= 1'b0;
        end else if (resume_r) begin
            susp_prog_r <= 1'b0;
            susp_erase_r <= 1'b0;
        end else if (susp_r) begin
            susp_prog_r <= !op_erase_r;
            susp_erase_r <= op_erase_r;
        end
    end

    // error bits: set wins over clear
    logic prog_err_r, erase_err_r;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prog_err_r <= 1'b0;
            erase_err_r <= 1'b0;
        end else begin
            prog_err_r <= bad_seq || engine_prog_err_in || (prog_err_r && !clr_status);
            erase_err_r <= bad_seq || engine_erase_err_in
                || (erase_err_r && !clr_status);
        end
    end

    // live status, frozen to the output only on a control toggle
    logic [7:0] status_live;
    always_comb begin
        status_live = 8'h00;
        status_live[ST_READY] = !engine_busy_in || engine_suspended_in;
        status_live[ST_ERASE_SUSP] = susp_erase_r;
        status_live[ST_ERASE_ERR] = erase_err_r;
        status_live[ST_PROG_ERR] = prog_err_r;
        status_live[ST_PROG_SUSP] = susp_prog_r;
    end
    logic ce_d_r, oe_d_r, av_d_r, seq_first_r;
    logic [7:0] status_r;
    wire refresh = (ce_q_r && !ce_d_r) || (oe_q_r && !oe_d_r) || (av_q_r && !av_d_r);
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ce_d_r <= 1'b1;
            oe_d_r <= 1'b1;
            av_d_r <= 1'b1;
            status_r <= STATUS_RESET;
            seq_first_r <= 1'b1;
        end else begin
            ce_d_r <= ce_q_r;
            oe_d_r <= oe_q_r;
            av_d_r <= av_q_r;
            seq_first_r <= 1'b0;
            if (refresh) status_r <= status_live;
        end
    end

    assign engine_start_out = start_r;
    assign engine_req_out = req_r;
    assign engine_suspend_out = susp_r;
    assign engine_resume_out = resume_r;
    assign engine_abort_out = rst_in || seq_first_r;
    assign buf_write_out = wr_end && state_r == S_BUF_DATA;
    assign buf_index_out = idx_r;
    assign buf_data_out = cyc_r.data;
    assign read_mode_out = 2'(rmode_r);
    assign status_view_out = status_r;

    // checks
    property p_err_hold;
        @(posedge clock_in) disable iff (rst_in)
        prog_err_r && !clr_status |=> prog_err_r;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error bit lost");
    property p_word_start;
        @(posedge clock_in) disable iff (rst_in)
        go_word |=> start_r && req_r.op == 3'(OP_WORD) && req_r.data == $past(cyc_r.data);
    endproperty
    a_word_start: assert property (p_word_start) else $error("word start wrong");
    property p_busy_ignore;
        @(posedge clock_in) disable iff (rst_in)
        state_r == S_BUSY && wr_end && code != CMD_SUSPEND |=> !start_r && !susp_r;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("busy acted");
    property p_erase_bad;
        @(posedge clock_in) disable iff (rst_in)
        wr_end && state_r == S_ERASE_CONFIRM && !is_confirm
            |=> prog_err_r && erase_err_r && rmode_r == RM_STATUS;
    endproperty
    a_erase_bad: assert property (p_erase_bad) else $error("no sequence error");
    property p_lock_bad;
        @(posedge clock_in) disable iff (rst_in)
        wr_end && state_r == S_LOCK_CODE && !is_lock_code |=> erase_err_r && !start_r;
    endproperty
    a_lock_bad: assert property (p_lock_bad) else $error("lock error missed");
    property p_susp;
        @(posedge clock_in) disable iff (rst_in)
        go_susp |=> susp_r ##1 (susp_prog_r != susp_erase_r);
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not shown");
    property p_status_still;
        @(posedge clock_in) disable iff (rst_in)
        !refresh |=> $stable(status_r);
    endproperty
    a_status_still: assert property (p_status_still) else $error("status moved");
    property p_factory_lock;
        @(posedge clock_in) disable iff (rst_in)
        state_r == S_FACTORY && engine_busy_in |=> state_r == S_FACTORY;
    endproperty
    a_factory_lock: assert property (p_factory_lock) else $error("factory left");
endmodule : fcd_decoder
`default_nettype wire

// ### tb/fcd_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_engine_model
    import fcd_pkg::*;
#(
    parameter int BUSY_CYC = 80
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // decoder requests and test failure input
    input wire logic start_in,
    input wire fcd_req_s req_in,
    input wire logic suspend_in,
    input wire logic resume_in,
    input wire logic abort_in,
    input wire logic fail_in,
    // engine state
    output logic busy_out,
    output logic suspended_out,
    output logic prog_err_out,
    output logic erase_err_out
);
    logic [7:0] cnt_r;
    logic [2:0] op_r;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            suspended_out <= 1'b0;
            prog_err_out <= 1'b0;
            erase_err_out <= 1'b0;
            cnt_r <= 8'h00;
            op_r <= 3'h0;
        end else begin
            prog_err_out <= 1'b0;
            erase_err_out <= 1'b0;
            if (abort_in) begin
                busy_out <= 1'b0;
                suspended_out <= 1'b0;
            end else if (start_in && !busy_out) begin
                busy_out <= 1'b1;
                cnt_r <= 8'(BUSY_CYC);
                op_r <= req_in.op;
            end else if (busy_out && suspend_in) begin
                busy_out <= 1'b0;
                suspended_out <= 1'b1;
            end else if (suspended_out && resume_in) begin
                busy_out <= 1'b1;
                suspended_out <= 1'b0;
            end else if (busy_out) begin
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    busy_out <= 1'b0;
                    // error bits only ever set from this side
                    prog_err_out <= fail_in && op_r != 3'(OP_ERASE);
                    erase_err_out <= fail_in && op_r == 3'(OP_ERASE);
                end
            end
        end
    end
endmodule : fcd_engine_model
`default_nettype wire

// ### tb/test_fcd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module test_fcd_decoder
    import fcd_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_n = 1'b1;
    logic we_n = 1'b1;
    logic oe_n = 1'b1;
    logic av_n = 1'b1;
    logic [23:0] addr = 24'h0;
    logic [15:0] dq = 16'h0;
    logic fail = 1'b0;
    logic busy, susp, perr, eerr, start, suspend, resume, abort, bwr;
    fcd_req_s req;
    logic [4:0] bidx;
    logic [15:0] bdata;
    logic [1:0] mode;
    logic [7:0] sv;
    int miscompares = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_susp = 0;
    int n_res = 0;
    int n_buf = 0;
    int exp_start = 0;
    logic [7:0] row_code [6] = '{8'h98, 8'hff, 8'h70, 8'hd0, 8'h98, 8'hff};
    logic [1:0] row_mode [6] = '{2'd2, 2'd0, 2'd1, 2'd1, 2'd2, 2'd0};
    logic [7:0] lock_code [3] = '{CMD_LOCK, CMD_CONFIRM, CMD_LOCK_DOWN};
    logic [2:0] lock_op [3] = '{3'(OP_LOCK), 3'(OP_UNLOCK), 3'(OP_LOCK_DOWN)};

    always #4 clock_in = ~clock_in;

    fcd_decoder uut (.clock_in(clock_in), .rst_in(rst_in), .ce_n_in(ce_n), .we_n_in(we_n),
        .oe_n_in(oe_n), .addr_valid_n_in(av_n), .addr_in(addr), .dq_in(dq),
        .engine_busy_in(busy), .engine_suspended_in(susp), .engine_prog_err_in(perr),
        .engine_erase_err_in(eerr), .engine_start_out(start), .engine_req_out(req),
        .engine_suspend_out(suspend), .engine_resume_out(resume), .engine_abort_out(abort),
        .buf_write_out(bwr), .buf_index_out(bidx), .buf_data_out(bdata),
        .read_mode_out(mode), .status_view_out(sv));

    fcd_engine_model #(.BUSY_CYC(80)) engine (.clock_in(clock_in), .rst_in(rst_in),
        .start_in(start), .req_in(req), .suspend_in(suspend), .resume_in(resume),
        .abort_in(abort), .fail_in(fail), .busy_out(busy), .suspended_out(susp),
        .prog_err_out(perr), .erase_err_out(eerr));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] time %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge clock_in) begin
        n_start += int'(start === 1'b1);
        n_susp += int'(suspend === 1'b1);
        n_res += int'(resume === 1'b1);
        if (bwr === 1'b1) begin
            check({bidx, bdata}, {5'(n_buf), 16'h1000 + 16'(n_buf)});
            n_buf++;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc

    // strobes held well past the three-flop synchroniser
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        addr = a;
        dq = d;
        ce_n = 1'b0;
        we_n = 1'b0;
        cyc(6);
        ce_n = 1'b1;
        we_n = 1'b1;
        cyc(7);
    endtask : wr

    task automatic refresh();
        ce_n = 1'b0;
        oe_n = 1'b0;
        av_n = 1'b0;
        cyc(6);
        ce_n = 1'b1;
        oe_n = 1'b1;
        av_n = 1'b1;
        cyc(7);
    endtask : refresh

    task automatic idle_wait();
        for (int i = 0; i < 300 && busy !== 1'b0; i++) cyc(1);
        check(busy, 1'b0);
    endtask : idle_wait

    task automatic expect_op(input logic [2:0] op, input logic [23:0] a, input logic [15:0] d);
        exp_start++;
        check(n_start, exp_start);
        check({req.op, req.addr, req.data}, {op, a, d});
    endtask : expect_op

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        finish_test();
    end

    initial begin
        cyc(2);
        check({abort, mode, sv}, {1'b1, 2'd0, STATUS_RESET});
        cyc(6);
        rst_in = 1'b0;
        cyc(2);
        for (int i = 0; i < 6; i++) begin
            wr(24'h0, {8'h00, row_code[i]});
            check(mode, row_mode[i]);
        end
        $display("test read modes done");
        for (int i = 0; i < 2; i++) begin
            wr(24'h000100, i ? 16'h0010 : 16'h0040);
            wr(24'h000100 + 24'(i), 16'h1234 + 16'(i));
            expect_op(3'(OP_WORD), 24'h000100 + 24'(i), 16'h1234 + 16'(i));
            check(mode, 2'd1);
            refresh();
            check(sv, 8'h00);
            idle_wait();
            check({mode, sv}, {2'd1, 8'h00});
            refresh();
            check(sv, 8'h80);
        end
        $display("test word program done");
        wr(24'h000200, 16'h0040);
        wr(24'h000200, 16'h5555);
        expect_op(3'(OP_WORD), 24'h000200, 16'h5555);
        wr(24'h0, 16'h00ff);
        wr(24'h0, 16'h0020);
        check({mode, n_start}, {2'd1, exp_start});
        wr(24'h00abcd, 16'h00b0);
        check(n_susp, 1);
        refresh();
        check(sv, 8'h84);
        wr(24'h0, 16'h00ff);
        cyc(20);
        check({n_res, susp}, {32'd0, 1'b1});
        wr(24'h00beef, 16'h00d0);
        check(n_res, 1);
        idle_wait();
        $display("test program suspend done");
        fail = 1'b1;
        wr(24'h010000, 16'h0020);
        wr(24'h012345, 16'h00d0);
        expect_op(3'(OP_ERASE), 24'h012345, 16'h00d0);
        wr(24'h0, 16'h0098);
        check(mode, 2'd1);
        wr(24'h0, 16'h00b0);
        refresh();
        check(sv, 8'hc0);
        wr(24'h0, 16'h00d0);
        idle_wait();
        fail = 1'b0;
        refresh();
        check({n_res, sv}, {32'd2, 8'ha0});
        wr(24'h0, 16'h0050);
        refresh();
        check(sv, 8'h80);
        wr(24'h0, 16'h0020);
        wr(24'h0, 16'h00ff);
        refresh();
        check({mode, sv, n_start}, {2'd1, 8'hb0, exp_start});
        wr(24'h0, 16'h0050);
        $display("test erase done");
        for (int i = 0; i < 3; i++) begin
            wr(24'h020000, 16'h0060);
            wr(24'h020000, {8'h00, lock_code[i]});
            expect_op(lock_op[i], 24'h020000, {8'h00, lock_code[i]});
            idle_wait();
        end
        wr(24'h020000, 16'h0060);
        wr(24'h020000, 16'h0070);
        refresh();
        check(sv, 8'hb0);
        wr(24'h0, 16'h0050);
        $display("test lock done");
        wr(24'h030000, 16'h00e8);
        wr(24'h030000, 16'd31);
        for (int i = 0; i < 32; i++) wr(24'h030000 + 24'(i), 16'h1000 + 16'(i));
        wr(24'h030000, 16'h00d0);
        exp_start++;
        check({n_buf, n_start}, {32'd32, exp_start});
        check({req.op, req.count}, {3'(OP_BUFFER), 6'd32});
        idle_wait();
        $display("test buffered program done");
        wr(24'h040000, 16'h0080);
        wr(24'h040010, 16'h00d0);
        expect_op(3'(OP_FACTORY), 24'h040010, 16'h00d0);
        wr(24'h0, 16'h00b0);
        wr(24'h0, 16'h0098);
        check({n_susp, mode}, {32'd2, 2'd1});
        idle_wait();
        $display("test factory program done");
        wr(24'h050000, 16'h0020);
        wr(24'h050000, 16'h00d0);
        expect_op(3'(OP_ERASE), 24'h050000, 16'h00d0);
        wr(24'h0, 16'h00b0);
        rst_in = 1'b1;
        cyc(2);
        check({abort, mode, sv}, {1'b1, 2'd0, STATUS_RESET});
        rst_in = 1'b0;
        cyc(3);
        check({susp, abort}, 2'b00);
        wr(24'h050000, 16'h0020);
        rst_in = 1'b1;
        cyc(2);
        rst_in = 1'b0;
        cyc(3);
        wr(24'h050000, 16'h00d0);
        check({n_start, n_res}, {exp_start, 32'd2});
        $display("test reset abort done");
        finish_test();
    end
endmodule : test_fcd_decoder
`default_nettype wire
